// file: bench/crosspoint_program_interface_tb.sv
`timescale 1ns/10ps
`default_nettype none
module crosspoint_program_interface_tb;
  import cxp_pkg::*;
  localparam logic [31:0] PAT = 32'ha5c3_1e69;
  logic core_clk, rst, so, soe;
  cxp_pins_s pins;
  cxp_route_s ro;
  logic [2:0] sel;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, em, es, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int n_fail, n_tests, cyc;

  cxp_program_if u_dut (
    .core_clk, .rst, .pins, .output_select_bits(sel), .shift_out_line(so), .shift_out_oe(soe), .route_out(ro),
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp
  );
  cxp_host_model u_host (.core_clk, .d1_oe(soe), .d1_out(so), .pins, .sel);

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      conclude();
    end
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Ready and answer are peeked at the falling edge, acted on at the rising one
  task automatic aw(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
    logic ta, tw, bd;
    bd = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!bd) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      bd = s_axi_bvalid;
      rs = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (bd) s_axi_bready <= 1'b0;
    end
  endtask : aw
  task automatic ar(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    logic ta, rd;
    rd = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rd) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      rd = s_axi_rvalid;
      v = s_axi_rdata;
      rs = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
      if (rd) s_axi_rready <= 1'b0;
    end
  endtask : ar
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    ar(a, d, r);
    chk(nm, e, d);
    chk({nm, "_resp"}, {30'h0, er}, {30'h0, r});
  endtask : rchk

  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hf;
    em = '0;
    repeat (10) @(posedge core_clk);
    rst <= 1'b0;
    u_host.idle(8);
    chk("route", 32'h0, ro.route);
    chk("enable", 32'hff, {24'h0, ro.enable});
    rchk("ctrl", CXP_OFS_CTRL, CXP_CTRL_RST, CXP_RESP_OKAY);
    rchk("status", CXP_OFS_STATUS, 32'h20, CXP_RESP_OKAY);
    // Level mode, every route code; the last write zeroes output 0
    for (int i = 0; i < 9; i++) begin
      u_host.wr(4'((i + 1) % 9), 3'(i));
      em[(i % 8) * 4 +: 4] = 4'((i + 1) % 9);
    end
    rchk("master", CXP_OFS_MASTER, em, CXP_RESP_OKAY);
    chk("slave", em, ro.route);
    chk("oe", 32'h0, {31'h0, soe});
    u_host.latch(1'b1);
    u_host.wr(4'h4, 3'h7);
    chk("slave", em, ro.route);
    em[31:28] = 4'h4;
    u_host.latch(1'b0);
    chk("slave", em, ro.route);
    u_host.wr(4'h9, 3'h3);
    u_host.wr(4'ha, 3'h4);
    rchk("master", CXP_OFS_MASTER, em, CXP_RESP_OKAY);
    $display("test level done");
    es = em;
    u_host.mode(1'b0, 1'b1);
    u_host.wr(4'h5, 3'h0);
    em[3:0] = 4'h5;
    chk("slave", es, ro.route);
    u_host.latch(1'b1);
    chk("slave", em, ro.route);
    u_host.latch(1'b0);
    es = em;
    u_host.wr(4'h6, 3'h1);
    em[7:4] = 4'h6;
    chk("slave", es, ro.route);
    u_host.wr(CXP_CMD_SW_LATCH, 3'h0);
    chk("slave", em, ro.route);
    es = em;
    u_host.wr(CXP_CMD_ONE_OFF, 3'h2);
    chk("enable", 32'hfb, {24'h0, ro.enable});
    u_host.wr(CXP_CMD_ALL_OFF, 3'h0);
    chk("enable", 32'h0, {24'h0, ro.enable});
    u_host.wr(CXP_CMD_ONE_ON, 3'h5);
    chk("enable", 32'h20, {24'h0, ro.enable});
    u_host.wr(CXP_CMD_ALL_ON, 3'h0);
    chk("enable", 32'hff, {24'h0, ro.enable});
    rchk("master", CXP_OFS_MASTER, em, CXP_RESP_OKAY);
    u_host.ena(1'b1, 1'b1);
    u_host.wr(4'h7, 3'h7);
    u_host.ena(1'b0, 1'b0);
    u_host.wr(4'h7, 3'h7);
    u_host.ena(1'b0, 1'b1);
    rchk("master", CXP_OFS_MASTER, em, CXP_RESP_OKAY);
    aw(CXP_OFS_CTRL, 32'h0, r);
    chk("ctrl_wr", {30'h0, CXP_RESP_OKAY}, {30'h0, r});
    u_host.wr(4'h7, 3'h7);
    rchk("master", CXP_OFS_MASTER, em, CXP_RESP_OKAY);
    aw(CXP_OFS_CTRL, CXP_CTRL_RST, r);
    aw(CXP_OFS_MASTER, 32'hffff_ffff, r);
    chk("master_wr", {30'h0, CXP_RESP_SLVERR}, {30'h0, r});
    rchk("hole", 8'h14, 32'h0, CXP_RESP_SLVERR);
    $display("test parallel done");
    u_host.mode(1'b1, 1'b1);
    for (int i = 31; i >= 0; i--) u_host.wr({2'b11, 1'b0, PAT[i]}, 3'h0);
    rchk("master", CXP_OFS_MASTER, PAT, CXP_RESP_OKAY);
    chk("enable", 32'hff, {24'h0, ro.enable});
    chk("shift_out", {31'h0, PAT[31]}, {31'h0, so});
    chk("oe", 32'h1, {31'h0, soe});
    chk("slave", es, ro.route);
    $display("test serial done");
    conclude();
  end
endmodule : crosspoint_program_interface_tb
`default_nettype wire

// file: bench/cxp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module cxp_host_model (
  input  wire logic          core_clk,
  input  wire logic          d1_oe,
  input  wire logic          d1_out,
  output cxp_pkg::cxp_pins_s pins,
  output logic [2:0]         sel
);
  import cxp_pkg::*;
  cxp_pins_s drv;
  // Shared data pin carries the device's shift-out while it drives
  always_comb begin
    pins = drv;
    if (d1_oe) pins.parallel_code_bus[1] = d1_out;
  end
  initial begin
    drv = '0;
    drv.chip_en = 1'b1;
    sel = 3'h0;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge core_clk);
  endtask : idle
  task automatic mode(input logic ser, input logic edg);
    drv.interface_select_strap <= ser;
    drv.transfer_mode_strap <= edg;
    idle(8);
  endtask : mode
  task automatic ena(input logic n, input logic e);
    drv.chip_en_n <= n;
    drv.chip_en <= e;
    idle(8);
  endtask : ena
  task automatic latch(input logic v);
    drv.latch_strobe <= v;
    idle(8);
  endtask : latch
  task automatic wr(input logic [3:0] code, input logic [2:0] a);
    drv.parallel_code_bus <= code;
    sel <= a;
    idle(6);
    drv.wr_strobe <= 1'b1;
    idle(6);
    drv.wr_strobe <= 1'b0;
    idle(6);
    // Released bus shows a changed value
    drv.parallel_code_bus <= ~code;
    sel <= ~a;
    idle(1);
  endtask : wr
endmodule : cxp_host_model
`default_nettype wire

// file: design/cxp_pkg.sv
package cxp_pkg;

  localparam int unsigned CXP_OUTPUTS    = 8;
  localparam int unsigned CXP_NIB_W      = 4;
  localparam int unsigned CXP_MASTER_W   = CXP_OUTPUTS * CXP_NIB_W;
  localparam int unsigned CXP_PIN_W      = 10;

  // Parallel code map
  localparam logic [3:0]  CXP_CODE_MAX_ROUTE = 4'h8;
  localparam logic [3:0]  CXP_CMD_ALL_OFF    = 4'hb;
  localparam logic [3:0]  CXP_CMD_ALL_ON     = 4'hc;
  localparam logic [3:0]  CXP_CMD_ONE_OFF    = 4'hd;
  localparam logic [3:0]  CXP_CMD_ONE_ON     = 4'he;
  localparam logic [3:0]  CXP_CMD_SW_LATCH   = 4'hf;

  // Register offsets
  localparam logic [7:0]  CXP_OFS_STATUS = 8'h00;
  localparam logic [7:0]  CXP_OFS_MASTER = 8'h04;
  localparam logic [7:0]  CXP_OFS_SLAVE  = 8'h08;
  localparam logic [7:0]  CXP_OFS_OUTEN  = 8'h0c;
  localparam logic [7:0]  CXP_OFS_CTRL   = 8'h10;

  // Field positions and reset values
  localparam int unsigned CXP_CTRL_GATE_BIT = 0;
  localparam logic [31:0] CXP_CTRL_RST      = 32'h0000_0001;
  localparam logic [31:0] CXP_REG_RST       = 32'h0000_0000;
  localparam logic [7:0]  CXP_OUTEN_RST     = 8'hff;
  localparam logic [CXP_PIN_W-1:0] CXP_PIN_RST = 10'h000;

  localparam logic [1:0]  CXP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CXP_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic       wr_strobe;
    logic       latch_strobe;
    logic       chip_en_n;
    logic       chip_en;
    logic       interface_select_strap;
    logic       transfer_mode_strap;
    logic [3:0] parallel_code_bus;
  } cxp_pins_s;

  typedef struct packed {
    logic [CXP_MASTER_W-1:0] route;
    logic [CXP_OUTPUTS-1:0]  enable;
  } cxp_route_s;

  function automatic logic [3:0] cxp_nib(input logic [CXP_MASTER_W-1:0] vec, input logic [2:0] idx);
    cxp_nib = vec[idx*CXP_NIB_W +: CXP_NIB_W];
  endfunction : cxp_nib

endpackage : cxp_pkg

// file: design/cxp_program_if.sv
`timescale 1ns/10ps
`default_nettype none

// Contract
// - In serial mode each accepted write edge shifts the serial input into the low end of the master register.
// - In parallel mode an accepted write edge with code 0 to 8 stores that code in the addressed output's slot.
// - In parallel mode codes 11 to 15 act as commands and are not stored.
// - In edge mode the slave register loads from the master only on a rising transfer strobe or on command 15.
// - In level mode the slave register follows the master while the transfer strobe is low.
// - Commands 11 to 14 act at once on the write edge in parallel mode only, regardless of transfer strobe or edge or level mode.
// - Command 15 copies the master register into the slave register like a transfer pulse.
// - The write strobe counts only while the low-active enable is 0 and the high-active enable is 1.
// - Parallel code bits 3 and 2 are used only in parallel mode and ignored in serial mode.
// - The interface strap selects serial mode when 1 and parallel mode when 0.
// - In serial mode the master register's top bit drives the shift-out line for daisy chaining.
// - In level mode with the transfer strobe low a change takes effect right after the write edge.
module cxp_program_if (
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire cxp_pkg::cxp_pins_s   pins,
  input  wire logic [2:0]           output_select_bits,
  output logic                      shift_out_line,
  output logic                      shift_out_oe,
  output cxp_pkg::cxp_route_s       route_out,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  output logic [1:0]                s_axi_bresp,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  input  wire logic [7:0]           s_axi_araddr,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp
);
  import cxp_pkg::*;

  logic [CXP_PIN_W-1:0]    sync1_reg, sync2_reg, sync3_reg, pin_reg;
  logic [2:0]              sel1_reg, sel2_reg, sel3_reg, sel_reg;
  cxp_pins_s               pin_s;
  logic                    wr_prev_reg, latch_prev_reg;
  logic                    wr_rise, latch_rise, accept, serial_mode, level_open;
  logic                    sw_latch, is_route, is_cmd;
  logic [3:0]              code;
  logic                    shift_in_line;
  logic [CXP_MASTER_W-1:0] master_reg, slave_reg;
  logic [CXP_OUTPUTS-1:0]  outen_reg;
  logic [31:0]             ctrl_reg;

  // Pin sampling: three stages, accept once stages two and three agree
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_reg <= CXP_PIN_RST;
      sync2_reg <= CXP_PIN_RST;
      sync3_reg <= CXP_PIN_RST;
      pin_reg   <= CXP_PIN_RST;
      sel1_reg  <= 3'h0;
      sel2_reg  <= 3'h0;
      sel3_reg  <= 3'h0;
      sel_reg   <= 3'h0;
    end else begin
      sync1_reg <= pins;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      pin_reg   <= (pin_reg & (sync2_reg ^ sync3_reg)) | (sync3_reg & ~(sync2_reg ^ sync3_reg));
      sel1_reg  <= output_select_bits;
      sel2_reg  <= sel1_reg;
      sel3_reg  <= sel2_reg;
      sel_reg   <= (sel_reg & (sel2_reg ^ sel3_reg)) | (sel3_reg & ~(sel2_reg ^ sel3_reg));
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_prev_reg    <= 1'b0;
      latch_prev_reg <= 1'b0;
    end else begin
      wr_prev_reg    <= pin_s.wr_strobe;
      latch_prev_reg <= pin_s.latch_strobe;
    end
  end

  assign pin_s         = cxp_pins_s'(pin_reg);
  assign serial_mode   = pin_s.interface_select_strap;
  assign shift_in_line = pin_s.parallel_code_bus[0];
  assign code          = pin_s.parallel_code_bus;
  assign wr_rise       = pin_s.wr_strobe & ~wr_prev_reg;
  assign latch_rise    = pin_s.latch_strobe & ~latch_prev_reg;
  assign accept        = wr_rise & ~pin_s.chip_en_n & pin_s.chip_en & ctrl_reg[CXP_CTRL_GATE_BIT];
  assign is_route      = accept & ~serial_mode & (code <= CXP_CODE_MAX_ROUTE);
  assign is_cmd        = accept & ~serial_mode & (code >= CXP_CMD_ALL_OFF);
  assign sw_latch      = is_cmd & (code == CXP_CMD_SW_LATCH);
  assign level_open    = ~pin_s.transfer_mode_strap & ~pin_s.latch_strobe;

  // Master register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      master_reg <= CXP_REG_RST;
    end else if (accept && serial_mode) begin
      master_reg <= {master_reg[CXP_MASTER_W-2:0], shift_in_line};
    end else if (is_route) begin
      master_reg[sel_reg*CXP_NIB_W +: CXP_NIB_W] <= code;
    end
  end

  // Output enables, driven by immediate commands
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      outen_reg <= CXP_OUTEN_RST;
    end else if (is_cmd) begin
      case (code)
        CXP_CMD_ALL_OFF: outen_reg <= '0;
        CXP_CMD_ALL_ON:  outen_reg <= '1;
        CXP_CMD_ONE_OFF: outen_reg[sel_reg] <= 1'b0;
        CXP_CMD_ONE_ON:  outen_reg[sel_reg] <= 1'b1;
        default:         outen_reg <= outen_reg;
      endcase
    end
  end

  // Slave register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slave_reg <= CXP_REG_RST;
    end else if (level_open) begin
      slave_reg <= master_reg;
    end else if (pin_s.transfer_mode_strap && latch_rise) begin
      slave_reg <= master_reg;
    end else if (sw_latch) begin
      slave_reg <= master_reg;
    end
  end

  assign route_out.route  = slave_reg;
  assign route_out.enable = outen_reg;
  assign shift_out_line   = master_reg[CXP_MASTER_W-1];
  assign shift_out_oe     = serial_mode;

  // AXI4-Lite write path
  logic       aw_got_reg, w_got_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;

  assign s_axi_awready = ~aw_got_reg & ~s_axi_bvalid;
  assign s_axi_wready  = ~w_got_reg & ~s_axi_bvalid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      aw_got_reg   <= 1'b0;
      w_got_reg    <= 1'b0;
      aw_addr_reg  <= 8'h00;
      w_data_reg   <= 32'h0000_0000;
      w_strb_reg   <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= CXP_RESP_OKAY;
      ctrl_reg     <= CXP_CTRL_RST;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_reg  <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_reg  <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (aw_got_reg && w_got_reg) begin
        aw_got_reg   <= 1'b0;
        w_got_reg    <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (aw_addr_reg[7:2] == CXP_OFS_CTRL[7:2]) begin
          if (w_strb_reg[0]) begin
            ctrl_reg[7:0] <= w_data_reg[7:0];
          end
          s_axi_bresp <= CXP_RESP_OKAY;
        end else begin
          s_axi_bresp <= CXP_RESP_SLVERR;
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= CXP_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= CXP_RESP_OKAY;
      if (s_axi_araddr[7:2] == CXP_OFS_STATUS[7:2]) begin
        s_axi_rdata <= {26'h0, pin_s.chip_en, pin_s.chip_en_n, pin_s.latch_strobe,
                        pin_s.wr_strobe, pin_s.transfer_mode_strap, serial_mode};
      end else if (s_axi_araddr[7:2] == CXP_OFS_MASTER[7:2]) begin
        s_axi_rdata <= master_reg;
      end else if (s_axi_araddr[7:2] == CXP_OFS_SLAVE[7:2]) begin
        s_axi_rdata <= slave_reg;
      end else if (s_axi_araddr[7:2] == CXP_OFS_OUTEN[7:2]) begin
        s_axi_rdata <= {24'h0, outen_reg};
      end else if (s_axi_araddr[7:2] == CXP_OFS_CTRL[7:2]) begin
        s_axi_rdata <= ctrl_reg;
      end else begin
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= CXP_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_lvl_write;
    accept && level_open;
  endsequence
  sequence s_par_cmd(logic [3:0] c);
    accept && !serial_mode && code == c;
  endsequence

  property p_shift;
    accept && serial_mode |=> master_reg == {$past(master_reg[CXP_MASTER_W-2:0]), $past(shift_in_line)};
  endproperty
  a_shift: assert property (p_shift) else $error("serial shift wrong");

  property p_store;
    is_route |=> cxp_nib(master_reg, $past(sel_reg)) == $past(code);
  endproperty
  a_store: assert property (p_store) else $error("route code not stored");

  property p_cmd_nostore;
    is_cmd |=> master_reg == $past(master_reg);
  endproperty
  a_cmd_nostore: assert property (p_cmd_nostore) else $error("command stored");

  property p_edge_hold;
    pin_s.transfer_mode_strap && !latch_rise && !sw_latch |=> slave_reg == $past(slave_reg);
  endproperty
  a_edge_hold: assert property (p_edge_hold) else $error("slave moved without transfer");

  property p_level_follow;
    level_open |=> slave_reg == $past(master_reg);
  endproperty
  a_level_follow: assert property (p_level_follow) else $error("slave not transparent");

  property p_all_off;
    s_par_cmd(CXP_CMD_ALL_OFF) |=> outen_reg == 8'h00;
  endproperty
  a_all_off: assert property (p_all_off) else $error("disable command late");

  property p_sw_latch;
    s_par_cmd(CXP_CMD_SW_LATCH) |=> slave_reg == $past(master_reg);
  endproperty
  a_sw_latch: assert property (p_sw_latch) else $error("software transfer missed");

  property p_gate;
    wr_rise && (pin_s.chip_en_n || !pin_s.chip_en) |=> master_reg == $past(master_reg);
  endproperty
  a_gate: assert property (p_gate) else $error("write taken while disabled");

  property p_chain;
    serial_mode |-> shift_out_oe && shift_out_line == master_reg[CXP_MASTER_W-1];
  endproperty
  a_chain: assert property (p_chain) else $error("shift out wrong");

  property p_lvl_write;
    s_lvl_write ##1 level_open |=> slave_reg == $past(master_reg, 1);
  endproperty
  a_lvl_write: assert property (p_lvl_write) else $error("level write not applied");

  property p_noop;
    accept && !serial_mode && (code == 4'h9 || code == 4'ha) |=>
      master_reg == $past(master_reg) && outen_reg == $past(outen_reg);
  endproperty
  a_noop: assert property (p_noop) else $error("reserved code acted");

endmodule : cxp_program_if

`default_nettype wire
